// file: hw/errlog_pkg.sv
// constants for the secondary-bus error log and control word
// assumes a 32-bit apb slave at byte offset 0x154 on a 100 MHz clock
package errlog_pkg;

	localparam logic [11:0] MISC_ERR_LOG_OFFSET = 12'h154;
	localparam int          APB_ADDR_W          = 12;
	localparam int          APB_DATA_W          = 32;

	// field positions inside the word
	localparam int ADDR_LOW_PARITY_BIT   = 15;
	localparam int REQUEST_LOG_VALID_BIT = 14;
	localparam int REQUEST_LINE_LOG_LSB  = 11;
	localparam int REQUEST_LINE_LOG_W    = 3;
	localparam int DATA_LOG_VALID_BIT    = 9;
	localparam int DATA_WIDTH_BIT        = 8;
	localparam int BYTE_ENABLE_LOG_LSB   = 0;
	localparam int BYTE_ENABLE_LOG_W     = 8;
	localparam int CLEAR_BYTE_LANE       = 1;

	// bus widths of the secondary side
	localparam int BUS_DATA_W = 64;
	localparam int HALF_DATA_W = 32;

	// reset values, all fields start empty
	localparam logic                          ADDR_LOW_PARITY_RST   = 1'b0;
	localparam logic                          REQUEST_LOG_VALID_RST = 1'b0;
	localparam logic [REQUEST_LINE_LOG_W-1:0] REQUEST_LINE_LOG_RST  = 3'h0;
	localparam logic                          DATA_LOG_VALID_RST    = 1'b0;
	localparam logic                          DATA_WIDTH_RST        = 1'b0;
	localparam logic [BYTE_ENABLE_LOG_W-1:0]  BYTE_ENABLE_LOG_RST   = 8'h00;
	localparam logic [BUS_DATA_W-1:0]         DATA_LOG_RST          = 64'h0;
	localparam logic [APB_DATA_W-1:0]         READ_ZERO             = 32'h0;

	// secondary bus operating modes
	typedef enum logic [1:0]
	{
		mode_pci        = 2'h0,
		mode_pcix_mode1 = 2'h1,
		mode_pcix_mode2 = 2'h3
	} bus_mode_t;

	// apb slave states
	typedef enum logic [0:0]
	{
		apb_idle   = 1'b0,
		apb_answer = 1'b1
	} apb_state_t;

endpackage : errlog_pkg

// file: hw/errlog_reg_if.sv
// carrier between the apb port and the log core
// assumes both ends run on the same clock
interface errlog_reg_if;
	import errlog_pkg::*;

	logic [APB_DATA_W-1:0]   rd_data;
	logic                    wr_strobe;
	logic [APB_DATA_W-1:0]   wr_data;
	logic [APB_DATA_W/8-1:0] wr_strb;

	modport port
	(
		input  rd_data,
		output wr_strobe,
		output wr_data,
		output wr_strb
	);

	modport core
	(
		output rd_data,
		input  wr_strobe,
		input  wr_data,
		input  wr_strb
	);

endinterface : errlog_reg_if

// file: hw/errlog_apb_port.sv
// apb slave for the single log word: decode, handshake, read capture
// assumes one apb master on clk; answers one cycle into the access phase
module errlog_apb_port
	import errlog_pkg::*;
(
	input  wire logic                    clk,
	input  wire logic                    resetn,
	input  wire logic [APB_ADDR_W-1:0]   paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [APB_DATA_W-1:0]   pwdata,
	input  wire logic [APB_DATA_W/8-1:0] pstrb,
	output logic      [APB_DATA_W-1:0]   prdata,
	output logic                         pready,
	output logic                         pslverr,
	errlog_reg_if.port                   regs
);

	apb_state_t state;
	logic       hit;

	wire setup_phase = psel & ~penable;
	wire addr_hit    = (paddr == MISC_ERR_LOG_OFFSET);
	wire finish      = (state == apb_answer) & psel & penable;

	// write lands on the very edge where pready is sampled high
	assign regs.wr_strobe = finish & pwrite & hit;
	assign regs.wr_data   = pwdata;
	assign regs.wr_strb   = pstrb;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state   <= apb_idle;
			hit     <= 1'b0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= READ_ZERO;
		end
		else
		begin
			case (state)
				apb_idle:
				begin
					if (setup_phase)
					begin
						state   <= apb_answer;
						hit     <= addr_hit;
						pready  <= 1'b1;
						pslverr <= ~addr_hit;
						prdata  <= (addr_hit && !pwrite) ? regs.rd_data : READ_ZERO;
					end
				end
				apb_answer:
				begin
					if (finish)
					begin
						state   <= apb_idle;
						pready  <= 1'b0;
						pslverr <= 1'b0;
						prdata  <= READ_ZERO;
					end
				end
				default:
				begin
					state  <= apb_idle;
					pready <= 1'b0;
				end
			endcase
		end
	end

endmodule : errlog_apb_port

// file: hw/pcix_error_log_low.sv
// low half of the secondary-bus error log and control word
// assumes secondary-bus event inputs come from logic on clk (no sync)
// and resetn is the sticky reset, so logs survive an ordinary bus reset
//
// Contract
// - requests/PCI: log parity of first address phase
// - completions: log parity of attribute clock
// - log driven parity when driving, else sampled
// - parity bit meaningful only in PCI-X mode 1
// - parity bit loads only on address parity error
// - parity bit holds until status clear
// - request log valid set; software writes one
// - capture master request line on parity errors
// - capture also on nonzero ecc error phase
// - request log frozen until valid cleared
// - request rearm depends only on own valid
// - data log valid set on each data capture
// - writing one to data valid rearms capture
// - width bit set for 64-bit logged data
// - target data errors log eight byte enables
// - byte enables undefined while data valid clear
// - 32-bit transfers log only low data half
module pcix_error_log_low
	import errlog_pkg::*;
#(
	parameter int REQ_LINE_W = REQUEST_LINE_LOG_W,
	parameter int BE_W       = BYTE_ENABLE_LOG_W
)
(
	input  wire logic                    clk,
	input  wire logic                    resetn,
	// apb register port
	input  wire logic [APB_ADDR_W-1:0]   paddr,
	input  wire logic                    psel,
	input  wire logic                    penable,
	input  wire logic                    pwrite,
	input  wire logic [APB_DATA_W-1:0]   pwdata,
	input  wire logic [APB_DATA_W/8-1:0] pstrb,
	output logic      [APB_DATA_W-1:0]   prdata,
	output logic                         pready,
	output logic                         pslverr,
	// secondary bus operating mode
	input  wire logic [1:0]              bus_mode,
	// address / attribute parity error report
	input  wire logic                    addr_par_err,
	input  wire logic                    is_pcix_completion,
	input  wire logic                    bridge_driving,
	input  wire logic                    low_phase_par_driven,
	input  wire logic                    low_phase_par_sampled,
	input  wire logic                    attr_clk_par_driven,
	input  wire logic                    attr_clk_par_sampled,
	input  wire logic                    unc_status_clear,
	// request-line capture sources
	input  wire logic                    bus_parity_err,
	input  wire logic                    ecc_phase_nonzero,
	input  wire logic [REQ_LINE_W-1:0]   master_req_line,
	// target data error report
	input  wire logic                    target_data_err,
	input  wire logic                    data_is_64,
	input  wire logic [BUS_DATA_W-1:0]   bus_data,
	input  wire logic [BE_W-1:0]         bus_byte_en,
	// log contents
	output logic                         address_low_parity,
	output logic                         request_log_valid,
	output logic      [REQ_LINE_W-1:0]   request_line_log,
	output logic                         data_log_valid,
	output logic                         logged_data_width,
	output logic      [BE_W-1:0]         byte_enable_log,
	output logic                         data_log_load,
	output logic      [BUS_DATA_W-1:0]   data_log_value
);

	// field layout is fixed by the register word
	if (REQ_LINE_W != REQUEST_LINE_LOG_W)
	begin : g_bad_req_w
		$error("request line width must match the log field");
	end
	if (BE_W != BYTE_ENABLE_LOG_W)
	begin : g_bad_be_w
		$error("byte enable width must match the log field");
	end

	errlog_reg_if regs ();

	errlog_apb_port u_port
	(
		.clk     (clk),
		.resetn  (resetn),
		.paddr   (paddr),
		.psel    (psel),
		.penable (penable),
		.pwrite  (pwrite),
		.pwdata  (pwdata),
		.pstrb   (pstrb),
		.prdata  (prdata),
		.pready  (pready),
		.pslverr (pslverr),
		.regs    (regs.port)
	);

	function automatic logic w1c_hit(input logic [APB_DATA_W-1:0] data,
		input logic [APB_DATA_W/8-1:0] strb, input int bit_pos);
		w1c_hit = strb[bit_pos / 8] & data[bit_pos];
	endfunction : w1c_hit

	// software clear strobes: a written zero or a masked lane does nothing
	wire clear_request_valid = regs.wr_strobe
		& w1c_hit(regs.wr_data, regs.wr_strb, REQUEST_LOG_VALID_BIT);
	wire clear_data_valid = regs.wr_strobe
		& w1c_hit(regs.wr_data, regs.wr_strb, DATA_LOG_VALID_BIT);

	// address-low parity
	logic addr_par_held;

	wire in_mode1 = (bus_mode == mode_pcix_mode1);

	// drive side records what went out, receive side what came in
	wire first_phase_par = bridge_driving ? low_phase_par_driven
		: low_phase_par_sampled;
	wire attr_clock_par = bridge_driving ? attr_clk_par_driven
		: attr_clk_par_sampled;

	// completions log the requester attribute clock instead
	wire selected_par = is_pcix_completion ? attr_clock_par
		: first_phase_par;

	// outside mode 1 the bit carries no meaning; zero keeps it quiet
	wire logged_par = in_mode1 & selected_par;

	// a clear in the same cycle as a new error lets the error in
	wire addr_par_arm  = ~addr_par_held | unc_status_clear;
	wire addr_par_load = addr_par_err & addr_par_arm;

	wire next_addr_par_held = addr_par_load | (addr_par_held & ~unc_status_clear);
	wire next_address_low_parity = addr_par_load ? logged_par
		: (unc_status_clear ? ADDR_LOW_PARITY_RST : address_low_parity);

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			addr_par_held      <= 1'b0;
			address_low_parity <= ADDR_LOW_PARITY_RST;
		end
		else
		begin
			addr_par_held      <= next_addr_par_held;
			address_low_parity <= next_address_low_parity;
		end
	end

	// request-line log
	wire request_source = bus_parity_err | ecc_phase_nonzero;

	// only the own valid bit gates rearm; other status registers are not looked at
	wire request_arm = ~request_log_valid | clear_request_valid;
	wire request_capture = request_source & request_arm;

	// set wins over a clear in the same cycle
	wire next_request_log_valid = request_capture
		| (request_log_valid & ~clear_request_valid);
	wire [REQ_LINE_W-1:0] next_request_line_log = request_capture ? master_req_line
		: request_line_log;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			request_log_valid <= REQUEST_LOG_VALID_RST;
			request_line_log  <= REQUEST_LINE_LOG_RST;
		end
		else
		begin
			request_log_valid <= next_request_log_valid;
			request_line_log  <= next_request_line_log;
		end
	end

	// data log, byte enables and width
	wire data_arm     = ~data_log_valid | clear_data_valid;
	wire data_capture = target_data_err & data_arm;

	wire next_data_log_valid = data_capture
		| (data_log_valid & ~clear_data_valid);

	// upper half forced to zero so stale bits never look like a capture
	wire [BUS_DATA_W-1:0] captured_data = data_is_64 ? bus_data
		: {{(BUS_DATA_W-HALF_DATA_W){1'b0}}, bus_data[HALF_DATA_W-1:0]};

	wire [BUS_DATA_W-1:0] next_data_log_value = data_capture ? captured_data
		: data_log_value;
	wire next_logged_data_width = data_capture ? data_is_64
		: logged_data_width;
	wire [BE_W-1:0] next_byte_enable_log = data_capture ? bus_byte_en
		: byte_enable_log;

	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			data_log_valid    <= DATA_LOG_VALID_RST;
			logged_data_width <= DATA_WIDTH_RST;
			byte_enable_log   <= BYTE_ENABLE_LOG_RST;
			data_log_value    <= DATA_LOG_RST;
			data_log_load     <= 1'b0;
		end
		else
		begin
			data_log_valid    <= next_data_log_valid;
			logged_data_width <= next_logged_data_width;
			byte_enable_log   <= next_byte_enable_log;
			data_log_value    <= next_data_log_value;
			data_log_load     <= data_capture;
		end
	end

	// read view; reserved bit 10 and everything above 15 read as zero
	always_comb
	begin
		regs.rd_data = READ_ZERO;
		regs.rd_data[ADDR_LOW_PARITY_BIT] = address_low_parity;
		regs.rd_data[REQUEST_LOG_VALID_BIT] = request_log_valid;
		regs.rd_data[REQUEST_LINE_LOG_LSB +: REQUEST_LINE_LOG_W] = request_line_log;
		regs.rd_data[DATA_LOG_VALID_BIT] = data_log_valid;
		regs.rd_data[DATA_WIDTH_BIT] = logged_data_width;
		regs.rd_data[BYTE_ENABLE_LOG_LSB +: BYTE_ENABLE_LOG_W] = byte_enable_log;
	end

endmodule : pcix_error_log_low

// file: test/errlog_properties.sv
// assertions on the ports of pcix_error_log_low
// assumes one clock domain and the async active-low sticky reset
module errlog_properties
	import errlog_pkg::*;
#(
	parameter int REQ_LINE_W = REQUEST_LINE_LOG_W,
	parameter int BE_W       = BYTE_ENABLE_LOG_W
)
(
	input wire logic                    clk,
	input wire logic                    resetn,
	input wire logic [APB_ADDR_W-1:0]   paddr,
	input wire logic                    psel,
	input wire logic                    penable,
	input wire logic                    pwrite,
	input wire logic [APB_DATA_W-1:0]   pwdata,
	input wire logic [APB_DATA_W/8-1:0] pstrb,
	input wire logic                    pready,
	input wire logic                    addr_par_err,
	input wire logic                    unc_status_clear,
	input wire logic                    bus_parity_err,
	input wire logic                    ecc_phase_nonzero,
	input wire logic [REQ_LINE_W-1:0]   master_req_line,
	input wire logic                    target_data_err,
	input wire logic                    data_is_64,
	input wire logic [BE_W-1:0]         bus_byte_en,
	input wire logic                    address_low_parity,
	input wire logic                    request_log_valid,
	input wire logic [REQ_LINE_W-1:0]   request_line_log,
	input wire logic                    data_log_valid,
	input wire logic                    logged_data_width,
	input wire logic [BE_W-1:0]         byte_enable_log,
	input wire logic                    data_log_load
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!resetn);
	// a clear only counts on a completed write to the mapped word
	wire wr_hit = psel && penable && pready && pwrite && pstrb[CLEAR_BYTE_LANE]
		&& paddr == MISC_ERR_LOG_OFFSET;
	wire clr_req = wr_hit && pwdata[REQUEST_LOG_VALID_BIT];
	wire clr_data = wr_hit && pwdata[DATA_LOG_VALID_BIT];
	wire req_ev = bus_parity_err || ecc_phase_nonzero;
	wire data_arm = target_data_err && (!data_log_valid || clr_data);

	a_req_capture: assert property (req_ev && (!request_log_valid || clr_req) |=>
		request_log_valid && request_line_log == $past(master_req_line))
		else $error("request line not captured");
	a_req_frozen: assert property (request_log_valid && !clr_req |=>
		request_log_valid && $stable(request_line_log))
		else $error("request log moved while held");
	a_req_rearm: assert property (clr_req && !req_ev |=> !request_log_valid)
		else $error("request valid not cleared");
	a_data_capture: assert property (data_arm |=> data_log_valid && data_log_load
		&& byte_enable_log == $past(bus_byte_en))
		else $error("data capture wrong");
	a_data_width: assert property (data_arm |=> logged_data_width == $past(data_is_64))
		else $error("width bit wrong");
	a_data_held: assert property (data_log_valid && !clr_data |=>
		data_log_valid && $stable(byte_enable_log))
		else $error("data log moved while held");
	a_data_rearm: assert property (clr_data && !target_data_err |=> !data_log_valid)
		else $error("data valid not cleared");
	a_pal_hold: assert property (!addr_par_err && !unc_status_clear |=>
		$stable(address_low_parity))
		else $error("parity bit changed alone");
	a_pal_clear: assert property (unc_status_clear && !addr_par_err |=> !address_low_parity)
		else $error("parity bit not cleared");
endmodule : errlog_properties

bind pcix_error_log_low errlog_properties
	#(.REQ_LINE_W(REQ_LINE_W), .BE_W(BE_W)) i_errlog_properties (.*);

// file: test/sec_bus_model.sv
// secondary-bus masters raising error events towards the log
// assumes the log samples every event on the rising edge of clk
module sec_bus_model
(
	input  wire logic clk,
	output logic      addr_par_err,
	output logic      is_pcix_completion,
	output logic      bridge_driving,
	output logic      low_phase_par_driven,
	output logic      low_phase_par_sampled,
	output logic      attr_clk_par_driven,
	output logic      attr_clk_par_sampled,
	output logic      unc_status_clear,
	output logic      bus_parity_err,
	output logic      ecc_phase_nonzero,
	output logic [2:0] master_req_line,
	output logic      target_data_err,
	output logic      data_is_64,
	output logic [63:0] bus_data,
	output logic [7:0] bus_byte_en
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{addr_par_err, unc_status_clear, bus_parity_err, ecc_phase_nonzero} = 4'h0;
		{is_pcix_completion, bridge_driving, target_data_err, data_is_64} = 4'h0;
		{low_phase_par_driven, low_phase_par_sampled} = 2'h0;
		{attr_clk_par_driven, attr_clk_par_sampled} = 2'h0;
		master_req_line = 3'h0;
		bus_data = 64'h0;
		bus_byte_en = 8'h00;
	end

	// one-cycle event; byte enables, data and width inverted afterwards, other qualifiers left as driven
	task automatic ev(input logic [4:0] k, input logic [7:0] q, input logic [63:0] d,
		input logic w);
		@(posedge clk);
		{target_data_err, ecc_phase_nonzero, bus_parity_err, unc_status_clear, addr_par_err} <= k;
		bus_byte_en <= q;
		master_req_line <= q[2:0];
		{is_pcix_completion, bridge_driving} <= {q[0], q[1]};
		bus_data <= d;
		{low_phase_par_driven, low_phase_par_sampled, attr_clk_par_driven} <= d[3:1];
		attr_clk_par_sampled <= d[0];
		data_is_64 <= w;
		@(posedge clk);
		{target_data_err, ecc_phase_nonzero, bus_parity_err, unc_status_clear, addr_par_err} <= 5'h0;
		bus_byte_en <= ~q;
		bus_data <= ~d;
		data_is_64 <= ~w;
	endtask : ev
endmodule : sec_bus_model

// file: test/tb.sv
// self-checking bench for the low error log word over apb
// assumes sec_bus_model raises the secondary-bus events
`define CHK(nm, e, g) cmp(nm, (g) === (e), 64'(e), 64'(g))
module tb
	import errlog_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ps;
	logic clk, resetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic [1:0] bus_mode;
	logic addr_par_err, is_pcix_completion, bridge_driving, unc_status_clear;
	logic low_phase_par_driven, low_phase_par_sampled, attr_clk_par_driven;
	logic attr_clk_par_sampled, bus_parity_err, ecc_phase_nonzero, target_data_err;
	logic data_is_64, address_low_parity, request_log_valid, data_log_valid;
	logic logged_data_width, data_log_load;
	logic [2:0] master_req_line, request_line_log;
	logic [7:0] bus_byte_en, byte_enable_log;
	logic [63:0] bus_data, data_log_value;
	int n_checks, n_mismatch;

	pcix_error_log_low i_pcix_error_log_low (.*);
	sec_bus_model i_sec_bus_model (.*);

	always #5 clk = ~clk;

	task automatic cmp(input string nm, input bit ok, input logic [63:0] e, g);
		n_checks++;
		if (!ok)
		begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask : cmp

	// holds the request until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		@(posedge clk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
		@(posedge clk);
		penable <= 1'b1;
		// no cycle count assumed; a lost answer is caught by the watchdog
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		{rd, err} = {prdata, pslverr};
		{psel, penable} <= 2'h0;
	endtask : apb

	task automatic rdc(input logic [31:0] e, m, input string nm);
		logic [31:0] d;
		logic x;
		apb(1'b0, MISC_ERR_LOG_OFFSET, 32'h0, d, x);
		`CHK(nm, e & m, d & m);
	endtask : rdc

	task automatic wr(input logic [31:0] v);
		logic [31:0] d;
		logic x;
		apb(1'b1, MISC_ERR_LOG_OFFSET, v, d, x);
	endtask : wr

	task automatic end_sim;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	initial
	begin
		repeat (3000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end

	initial
	begin
		logic [31:0] d;
		logic x;
		logic [3:0] p;
		{clk, resetn, psel, penable, pwrite, paddr, pwdata} = '0;
		pstrb = 4'hf;
		bus_mode = mode_pcix_mode1;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rdc(32'h0, 32'hffff_ffff, "reset word");
		i_sec_bus_model.ev(5'h10, 8'h5a, 64'h1122_3344_5566_7788, 1'b1);
		rdc(32'h35a, 32'h3ff, "data capture");
		`CHK("data value", 64'h1122_3344_5566_7788, data_log_value);
		i_sec_bus_model.ev(5'h10, 8'h0f, 64'h0, 1'b0);
		rdc(32'h35a, 32'h3ff, "data held");
		`CHK("value held", 64'h1122_3344_5566_7788, data_log_value);
		wr(32'h0);
		rdc(32'h35a, 32'h3ff, "zero write");
		apb(1'b1, 12'h158, 32'h4200, d, x);
		`CHK("unmapped", 1'b1, x);
		rdc(32'h35a, 32'h3ff, "unmapped ignored");
		// a clear with its byte lane masked must not land
		pstrb <= 4'hd;
		wr(32'h200);
		pstrb <= 4'hf;
		rdc(32'h35a, 32'h3ff, "masked lane");
		wr(32'h200);
		rdc(32'h0, 32'h200, "data cleared");
		i_sec_bus_model.ev(5'h10, 8'h0c, 64'hffff_0000_aaaa_5555, 1'b0);
		rdc(32'h20c, 32'h3ff, "narrow capture");
		`CHK("low half", 64'h0000_0000_aaaa_5555, data_log_value);
		$display("data log test done");
		i_sec_bus_model.ev(5'h04, 8'h05, 64'h0, 1'b0);
		rdc(32'h6800, 32'hf800, "req capture");
		i_sec_bus_model.ev(5'h08, 8'h02, 64'h0, 1'b0);
		rdc(32'h6800, 32'hf800, "req frozen");
		i_sec_bus_model.ev(5'h02, 8'h00, 64'h0, 1'b0);
		i_sec_bus_model.ev(5'h04, 8'h03, 64'h0, 1'b0);
		rdc(32'h6800, 32'hf800, "req no rearm");
		wr(32'h4000);
		rdc(32'h0, 32'h4000, "req cleared");
		i_sec_bus_model.ev(5'h08, 8'h02, 64'h0, 1'b0);
		rdc(32'h5000, 32'h7800, "ecc capture");
		$display("request log test done");
		// selected parity value: attr for completions, driven when driving
		for (int i = 0; i < 8; i++)
		begin
			p = 4'h1 << ((i[0] ? 0 : 2) + (i[1] ? 1 : 0));
			i_sec_bus_model.ev(5'h01, {6'h0, i[1:0]}, {60'h0, i[2] ? p : ~p}, 1'b0);
			rdc({16'h0, i[2], 15'h0}, 32'h8000, "parity bit");
			i_sec_bus_model.ev(5'h02, 8'h00, 64'h0, 1'b0);
			rdc(32'h0, 32'h8000, "parity cleared");
		end
		// outside mode 1 the bit loads as zero and still holds until cleared
		bus_mode <= mode_pci;
		i_sec_bus_model.ev(5'h01, 8'h00, 64'h4, 1'b0);
		bus_mode <= mode_pcix_mode1;
		i_sec_bus_model.ev(5'h01, 8'h00, 64'h4, 1'b0);
		rdc(32'h0, 32'h8000, "parity outside mode 1");
		i_sec_bus_model.ev(5'h02, 8'h00, 64'h0, 1'b0);
		i_sec_bus_model.ev(5'h01, 8'h00, 64'h4, 1'b0);
		rdc(32'h8000, 32'h8000, "parity rearmed");
		i_sec_bus_model.ev(5'h02, 8'h00, 64'h0, 1'b0);
		$display("parity test done");
		// sticky reset in mid-run wipes every held log
		resetn <= 1'b0;
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		rdc(32'h0, 32'hffff_ffff, "sticky reset");
		`CHK("value reset", 64'h0, data_log_value);
		$display("reset test done");
		end_sim();
	end
endmodule : tb
